/* common/ir_mod_defs.svh */
// Purpose: offsets, field positions, reset values and timing figures
// Assumes: included by bare name after the package
// Notes: byte addresses on a 32-bit word bus
`ifndef IR_MOD_DEFS_SVH
`define IR_MOD_DEFS_SVH

// ==========================================
// register byte offsets
`define IRM_CTRL_OFF 8'h00
`define IRM_TMO_OFF 8'h04
`define IRM_GPIO_OFF 8'h08
`define IRM_STAT_OFF 8'h0c
`define IRM_MODE_OFF 8'hf0

// ==========================================
// field positions
`define IRM_FLOAT_BIT 5
`define IRM_SH_DATA_BIT 3
`define IRM_SH_POL_BIT 4
`define IRM_ALT_DATA_BIT 0

// ==========================================
// reset values and limits
`define IRM_CTRL_RST 7'h00
`define IRM_TMO_RST 7'h00
`define IRM_TMO_MAX 7'h64

// ==========================================
// timing figures in their own units
`define IRM_CLK_HZ 100000000
`define IRM_STEP_US 100
`define IRM_CARRIER_KHZ 500
`define IRM_PULSE_NS 1600
`define IRM_PULSE_MAX_BPS 115200
`define IRM_ASK_MAX_BAUD 19200

`endif

/* common/ir_mod_pkg.sv */
// Purpose: types shared by the infrared modulator and its bench
// Assumes: nothing
// Notes: control fields are packed with activate in bit 0
package ir_mod_pkg;

  typedef struct packed {
    logic alt_gpio;
    logic sh_serial;
    logic route_alt;
    logic half_dup;
    logic ask;
    logic ir_en;
    logic activate;
  } ctrl_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic port_b_serial_tx_pin_o;
    logic port_b_serial_tx_pin_oe;
    logic alt_ir_tx_pin_o;
    logic alt_ir_tx_pin_oe;
  } tx_pins_t;

  typedef struct packed {
    ctrl_t ctrl;
    logic [6:0] tmo;
    logic sh_data;
    logic sh_pol;
    logic alt_data;
    logic tx_float;
    logic [15:0] pre;
    logic [6:0] steps;
    logic tmr_on;
    logic last_tx;
    logic was_busy;
    logic [7:0] car_cnt;
    logic car;
    logic [7:0] pulse_cnt;
    logic ir_tx;
    logic rx_out;
    logic sh_out;
    logic sh_oe;
    logic alt_out;
    logic alt_oe;
    logic [31:0] prdata;
    logic pslverr;
  } irm_state_t;

endpackage : ir_mod_pkg

/* design/infrared_uart_modulator.sv */
// Purpose: infrared front end of the second serial port
// Assumes: uart core gives tx level, bit-start tick and busy flags
// Notes: rstn is the main-supply reset, standby_rstn the standby one
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ir_mod_defs.svh"

// Function
// - pulse mode sends one short pulse at bit start for zero, none for one.
// - each character starts with a zero start bit, then its bits serially.
// - keyed mode sends 500KHz carrier all bit long for zero, nothing for one.
// - keyed mode supports rates up to 19.2K baud.
// - half duplex starts timeout at last sent bit, blocks receive until expiry.
// - new transmit data before expiry restarts the timeout after that byte.
// - transmit loaded while receiving waits for timeout after last received bit.
// - new start bit during timeout restarts it after that character ends.
// - timeout programmable from zero to 10 ms in 100 us steps.
// - infrared uses normal serial pins or alternate pins, by configuration.
// - after standby reset both transmit pins drive low until enabled.
// - alternate pin defaults to infrared, low until selected and activated.
// - alternate pin as gpio stays low after reset, then follows its data bit.
// - shared pin defaults gpio; serial and active, it follows infrared or uart.
// - float control, bit 5 at 0xf0, tristates the shared pin unconditionally.
// - float survives main-supply loss; only a standby reset clears it.
// - shared pin as gpio stays low until data bit 3 or polarity is set.
// - deactivating the port drives the shared transmit pin low.
// - the alternate transmit pin ignores the float control.
module infrared_uart_modulator #(
  parameter int STEP_CYCLES = (`IRM_CLK_HZ / 1000000) * `IRM_STEP_US
) (
  // clock, resets, enable
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic standby_rstn,
  input wire logic ce,
  // register bus
  input wire ir_mod_pkg::apb_req_t apb,
  output ir_mod_pkg::apb_rsp_t apb_rsp,
  // uart core side
  input wire logic uart_txd,
  input wire logic uart_bit_tick,
  input wire logic uart_tx_busy,
  input wire logic uart_rx_busy,
  output logic uart_rxd,
  output logic tx_hold,
  output logic rx_block,
  // transceiver pins
  output ir_mod_pkg::tx_pins_t tx_pins,
  input wire logic port_b_serial_rx_pin,
  input wire logic alt_ir_rx_pin
);
  import ir_mod_pkg::*;

  // ==========================================
  // derived cycle counts
  localparam int HALF_CAR = `IRM_CLK_HZ / (`IRM_CARRIER_KHZ * 2000);
  localparam int PULSE_CYC = (`IRM_PULSE_NS * (`IRM_CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [7:0] HALF_CAR_M1 = 8'(HALF_CAR - 1);
  localparam logic [7:0] PULSE_LEN = 8'(PULSE_CYC);
  localparam logic [15:0] STEP_M1 = 16'(STEP_CYCLES - 1);
  // rates are paced by the uart tick; these only document the ceilings
  localparam int PULSE_MAX_BPS = `IRM_PULSE_MAX_BPS;
  localparam int ASK_MAX_BAUD = `IRM_ASK_MAX_BAUD;

  localparam irm_state_t ST_RST = '{
    ctrl: `IRM_CTRL_RST,
    tmo: `IRM_TMO_RST,
    rx_out: 1'b1,
    sh_oe: 1'b1,
    alt_oe: 1'b1,
    default: '0
  };

  irm_state_t st;
  irm_state_t nx;
  logic busy;
  logic rx_src;

  // ==========================================
  // address decode
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `IRM_CTRL_OFF) || (a == `IRM_TMO_OFF) ||
                (a == `IRM_GPIO_OFF) || (a == `IRM_STAT_OFF) ||
                (a == `IRM_MODE_OFF);
  endfunction : is_mapped

  function automatic logic [31:0] read_word(input irm_state_t s, input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0;
    case (a)
      `IRM_CTRL_OFF: w[6:0] = s.ctrl;
      `IRM_TMO_OFF: w[6:0] = s.tmo;
      `IRM_GPIO_OFF: begin
        w[`IRM_SH_DATA_BIT] = s.sh_data;
        w[`IRM_SH_POL_BIT] = s.sh_pol;
        w[`IRM_ALT_DATA_BIT] = s.alt_data;
      end
      `IRM_STAT_OFF: w[4:0] = {s.ir_tx, s.was_busy, s.last_tx, s.tmr_on, s.rx_out};
      `IRM_MODE_OFF: w[`IRM_FLOAT_BIT] = s.tx_float;
      default: w = 32'h0;
    endcase
    read_word = w;
  endfunction : read_word

  // ==========================================
  // handshake outputs
  assign busy = uart_tx_busy | uart_rx_busy;
  // receiver blocked while sending and during a turnaround after sending
  assign rx_block = st.ctrl.half_dup &
                    (uart_tx_busy | (st.tmr_on & st.last_tx));
  // sending held while receiving and during a turnaround after receiving
  assign tx_hold = st.ctrl.half_dup &
                   (uart_rx_busy | (st.tmr_on & ~st.last_tx));
  assign rx_src = (st.ctrl.ir_en & st.ctrl.route_alt) ?
                  alt_ir_rx_pin : port_b_serial_rx_pin;

  // zero wait states: read data is latched in the setup cycle
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.prdata = st.prdata;
  assign apb_rsp.pslverr = st.pslverr;
  assign uart_rxd = st.rx_out;
  assign tx_pins.port_b_serial_tx_pin_o = st.sh_out;
  assign tx_pins.port_b_serial_tx_pin_oe = st.sh_oe;
  assign tx_pins.alt_ir_tx_pin_o = st.alt_out;
  assign tx_pins.alt_ir_tx_pin_oe = st.alt_oe;

  // ==========================================
  // next state
  always_comb begin
    nx = st;

    // bus slave
    if (apb.psel && !apb.penable) begin
      nx.prdata = read_word(st, apb.paddr);
      nx.pslverr = !is_mapped(apb.paddr);
    end
    if (apb.psel && apb.penable && apb.pwrite) begin
      case (apb.paddr)
        `IRM_CTRL_OFF: nx.ctrl = apb.pwdata[6:0];
        `IRM_TMO_OFF: begin
          // values past the top are clipped to 10 ms
          nx.tmo = (apb.pwdata[6:0] > `IRM_TMO_MAX) ?
                   `IRM_TMO_MAX : apb.pwdata[6:0];
        end
        `IRM_GPIO_OFF: begin
          nx.sh_data = apb.pwdata[`IRM_SH_DATA_BIT];
          nx.sh_pol = apb.pwdata[`IRM_SH_POL_BIT];
          nx.alt_data = apb.pwdata[`IRM_ALT_DATA_BIT];
        end
        `IRM_MODE_OFF: nx.tx_float = apb.pwdata[`IRM_FLOAT_BIT];
        default: nx.tx_float = st.tx_float;
      endcase
    end

    // turnaround timer
    nx.was_busy = busy;
    if (!st.ctrl.half_dup || st.tmo == 7'h00) begin
      nx.tmr_on = 1'b0;
    end else if (busy) begin
      // any new character cancels the count; it restarts when it ends
      nx.tmr_on = 1'b0;
      nx.last_tx = uart_tx_busy;
    end else if (st.was_busy) begin
      nx.tmr_on = 1'b1;
      nx.pre = 16'h0;
      nx.steps = 7'h00;
    end else if (st.tmr_on) begin
      if (st.pre == STEP_M1) begin
        nx.pre = 16'h0;
        nx.steps = st.steps + 7'h01;
        if (st.steps + 7'h01 >= st.tmo) begin
          nx.tmr_on = 1'b0;
        end
      end else begin
        nx.pre = st.pre + 16'h1;
      end
    end
    if (busy && uart_rx_busy && !uart_tx_busy) begin
      nx.last_tx = 1'b0;
    end

    // keyed carrier, running only while a zero bit is on the line
    if (st.ctrl.ir_en && st.ctrl.ask && !uart_txd) begin
      if (st.car_cnt == HALF_CAR_M1) begin
        nx.car_cnt = 8'h00;
        nx.car = ~st.car;
      end else begin
        nx.car_cnt = st.car_cnt + 8'h01;
      end
    end else begin
      nx.car_cnt = 8'h00;
      nx.car = 1'b0;
    end

    // one pulse per zero bit, launched on the bit-start tick
    if (st.ctrl.ir_en && !st.ctrl.ask && uart_bit_tick && !uart_txd) begin
      nx.pulse_cnt = PULSE_LEN;
    end else if (st.pulse_cnt != 8'h00) begin
      nx.pulse_cnt = st.pulse_cnt - 8'h01;
    end
    // start bit arrives as a zero level from the uart core
    nx.ir_tx = st.ctrl.ask ? nx.car : (nx.pulse_cnt != 8'h00);

    // shared transmit pin
    if (st.tx_float) begin
      nx.sh_oe = 1'b0;
      nx.sh_out = 1'b0;
    end else if (!st.ctrl.sh_serial) begin
      nx.sh_oe = 1'b1;
      nx.sh_out = st.sh_data ^ st.sh_pol;
    end else if (!st.ctrl.activate) begin
      nx.sh_oe = 1'b1;
      nx.sh_out = 1'b0;
    end else begin
      nx.sh_oe = 1'b1;
      nx.sh_out = (st.ctrl.ir_en && !st.ctrl.route_alt) ?
                  st.ir_tx : uart_txd;
    end

    // alternate pin: always driven, float control not looked at
    nx.alt_oe = 1'b1;
    if (st.ctrl.alt_gpio) begin
      nx.alt_out = st.alt_data;
    end else begin
      nx.alt_out = st.ctrl.activate & st.ctrl.ir_en &
                   st.ctrl.route_alt & st.ir_tx;
    end

    // receive path idles high while blocked
    nx.rx_out = rx_block ? 1'b1 : rx_src;
  end

  // ==========================================
  // state register
  always_ff @(posedge sys_clk) begin
    if (!standby_rstn) begin
      st <= ST_RST;
    end else if (!rstn) begin
      st <= ST_RST;
      // float lives on the standby supply and survives main reset
      st.tx_float <= st.tx_float;
      st.sh_oe <= ~st.tx_float;
    end else if (ce) begin
      st <= nx;
    end
  end

  // ==========================================
  // assertions
  a_float_tristate: assert property (@(posedge sys_clk) disable iff (!rstn)
    st.tx_float && $past(st.tx_float) && $past(ce) |-> !st.sh_oe)
    else $error("shared pin driven while float set");

  a_alt_ignores_float: assert property (@(posedge sys_clk) disable iff (!standby_rstn)
    st.alt_oe)
    else $error("alternate pin not driven");

  a_deact_low: assert property (@(posedge sys_clk) disable iff (!rstn)
    $past(ce) && $past(st.ctrl.sh_serial) && !$past(st.ctrl.activate) &&
    !$past(st.tx_float) |-> st.sh_oe && !st.sh_out)
    else $error("inactive port shared pin not low");

  a_rx_blocked_tx: assert property (@(posedge sys_clk) disable iff (!rstn)
    ce && st.ctrl.half_dup && uart_tx_busy |=> st.rx_out)
    else $error("receive not blocked while sending");

  // a receive ending must hold off sending for the next cycle
  a_tx_held_rx: assert property (@(posedge sys_clk) disable iff (!rstn)
    ce && st.ctrl.half_dup && st.tmo != 7'h00 && st.was_busy && !busy && !st.last_tx &&
    !(apb.psel && apb.penable && apb.pwrite) |=> tx_hold)
    else $error("transmit not held after receive");

  a_rx_restart: assert property (@(posedge sys_clk) disable iff (!rstn)
    ce && st.ctrl.half_dup && st.tmr_on && uart_rx_busy && !uart_tx_busy
    |=> !st.tmr_on && !st.last_tx)
    else $error("turnaround not restarted by receive");

  a_timer_start: assert property (@(posedge sys_clk) disable iff (!rstn)
    ce && st.ctrl.half_dup && st.was_busy && !busy && st.tmo != 7'h00
    |=> st.tmr_on && st.steps == 7'h00)
    else $error("turnaround did not start");

  a_zero_tmo: assert property (@(posedge sys_clk) disable iff (!rstn)
    $past(ce) && $past(st.tmo) == 7'h00 |-> !st.tmr_on)
    else $error("timer runs with zero timeout");

  a_tmo_clip: assert property (@(posedge sys_clk) disable iff (!rstn)
    st.tmo <= `IRM_TMO_MAX)
    else $error("timeout above 10 ms");

  a_pulse_start: assert property (@(posedge sys_clk) disable iff (!rstn)
    ce && st.ctrl.ir_en && !st.ctrl.ask && uart_bit_tick && !uart_txd
    |=> st.ir_tx && st.pulse_cnt == PULSE_LEN)
    else $error("zero bit pulse missing");

  a_carrier_toggle: assert property (@(posedge sys_clk) disable iff (!rstn)
    ce && st.ctrl.ir_en && st.ctrl.ask && !uart_txd && st.car_cnt == HALF_CAR_M1
    |=> st.car != $past(st.car))
    else $error("carrier half period wrong");

  a_standby_pins: assert property (@(posedge sys_clk)
    !standby_rstn |=> st.sh_oe && !st.sh_out && st.alt_oe && !st.alt_out)
    else $error("pins not driven low after standby reset");

  a_main_keeps_float: assert property (@(posedge sys_clk) disable iff (!standby_rstn)
    !rstn |=> st.tx_float == $past(st.tx_float))
    else $error("float lost in main reset");

  a_alt_gpio: assert property (@(posedge sys_clk) disable iff (!rstn || !standby_rstn)
    ce && st.ctrl.alt_gpio |=> st.alt_out == $past(st.alt_data))
    else $error("alternate gpio data not followed");

  a_alt_low: assert property (@(posedge sys_clk) disable iff (!rstn || !standby_rstn)
    ce && !st.ctrl.alt_gpio && !(st.ctrl.activate && st.ctrl.ir_en && st.ctrl.route_alt)
    |=> !st.alt_out)
    else $error("alternate pin not low before enable");

  a_gpio_shared: assert property (@(posedge sys_clk) disable iff (!rstn || !standby_rstn)
    ce && !st.tx_float && !st.ctrl.sh_serial
    |=> st.sh_oe && st.sh_out == ($past(st.sh_data) ^ $past(st.sh_pol)))
    else $error("shared gpio value wrong");

  a_serial_follow: assert property (@(posedge sys_clk) disable iff (!rstn || !standby_rstn)
    ce && !st.tx_float && st.ctrl.sh_serial && st.ctrl.activate &&
    !(st.ctrl.ir_en && !st.ctrl.route_alt) |=> st.sh_out == $past(uart_txd))
    else $error("shared pin not following uart");

  a_rx_route: assert property (@(posedge sys_clk) disable iff (!rstn || !standby_rstn)
    ce && !rx_block && st.ctrl.ir_en && st.ctrl.route_alt
    |=> uart_rxd == $past(alt_ir_rx_pin))
    else $error("receive not taken from alternate pin");

  a_carrier_off: assert property (@(posedge sys_clk) disable iff (!rstn)
    ce && st.ctrl.ask && uart_txd |=> !st.ir_tx)
    else $error("carrier sent for a one bit");

  a_pulse_one: assert property (@(posedge sys_clk) disable iff (!rstn)
    ce && st.ctrl.ir_en && !st.ctrl.ask && uart_bit_tick && uart_txd &&
    st.pulse_cnt == 8'h00 |=> !st.ir_tx)
    else $error("pulse sent for a one bit");

  c_rx_turnaround: cover property (@(posedge sys_clk) disable iff (!rstn)
    tx_hold && !uart_rx_busy);
  c_float: cover property (@(posedge sys_clk) disable iff (!rstn)
    st.tx_float && !st.sh_oe);
  c_pulse: cover property (@(posedge sys_clk) disable iff (!rstn)
    $rose(st.ir_tx) && !st.ctrl.ask);
  c_carrier: cover property (@(posedge sys_clk) disable iff (!rstn)
    $rose(st.car));
  c_expire: cover property (@(posedge sys_clk) disable iff (!rstn)
    $fell(st.tmr_on) && !busy);

endmodule : infrared_uart_modulator
`default_nettype wire

/* dv/ir_xcvr_model.sv */
// Purpose: infrared transceiver at the far side of the pins
// Assumes: pins sampled on rising sys_clk
// Notes: counts light edges on each tx pin and light cycles on the shared pin only
`timescale 1ns/10ps
`default_nettype none
module ir_xcvr_model (
  // clock
  input wire logic sys_clk,
  // pins of the block
  input wire ir_mod_pkg::tx_pins_t tx_pins,
  output logic port_b_serial_rx_pin,
  output logic alt_ir_rx_pin,
  // bench side
  input wire logic rx_level,
  output int sh_rises,
  output int sh_high,
  output int alt_rises
);
  import ir_mod_pkg::*;
  int sr = 0;
  int sh = 0;
  int ar = 0;
  logic sh_d = 1'b0;
  logic alt_d = 1'b0;
  logic sh_now;
  // a floated pin emits no light
  assign sh_now = tx_pins.port_b_serial_tx_pin_o & tx_pins.port_b_serial_tx_pin_oe;
  assign port_b_serial_rx_pin = rx_level;
  assign alt_ir_rx_pin = rx_level;
  assign sh_rises = sr;
  assign sh_high = sh;
  assign alt_rises = ar;
  always @(posedge sys_clk) begin
    if (sh_now && !sh_d) sr++;
    if (sh_now) sh++;
    if (tx_pins.alt_ir_tx_pin_o && !alt_d) ar++;
    sh_d = sh_now;
    alt_d = tx_pins.alt_ir_tx_pin_o;
  end
endmodule : ir_xcvr_model
`default_nettype wire

/* dv/tb_infrared_uart_modulator.sv */
// Purpose: self-checking bench of the infrared modulator
// Assumes: timeout step shortened to 10 cycles
// Notes: reads are checked from a queue by a watcher process
`timescale 1ns/10ps
`default_nettype none
`include "ir_mod_defs.svh"
module tb_infrared_uart_modulator;
  import ir_mod_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic standby_rstn = 1'b0;
  apb_req_t apb = '0;
  apb_rsp_t apb_rsp;
  logic uart_txd = 1'b1;
  logic uart_bit_tick = 1'b0;
  logic uart_tx_busy = 1'b0;
  logic uart_rx_busy = 1'b0;
  logic rx_level = 1'b1;
  logic ce = 1'b1;
  logic uart_rxd, tx_hold, rx_block, sh_rx, alt_rx;
  tx_pins_t tx_pins;
  int sh_rises, sh_high, alt_rises;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [16:0] lfsr = 17'h1567c;
  logic [32:0] exp_q[$];

  infrared_uart_modulator #(.STEP_CYCLES(10)) u_infrared_uart_modulator (
    .sys_clk(sys_clk), .rstn(rstn), .standby_rstn(standby_rstn), .ce(ce),
    .apb(apb), .apb_rsp(apb_rsp), .uart_txd(uart_txd), .uart_bit_tick(uart_bit_tick),
    .uart_tx_busy(uart_tx_busy), .uart_rx_busy(uart_rx_busy), .uart_rxd(uart_rxd),
    .tx_hold(tx_hold), .rx_block(rx_block), .tx_pins(tx_pins),
    .port_b_serial_rx_pin(sh_rx), .alt_ir_rx_pin(alt_rx));
  ir_xcvr_model u_ir_xcvr_model (
    .sys_clk(sys_clk), .tx_pins(tx_pins), .port_b_serial_rx_pin(sh_rx),
    .alt_ir_rx_pin(alt_rx), .rx_level(rx_level), .sh_rises(sh_rises),
    .sh_high(sh_high), .alt_rises(alt_rises));

  // ==========================================
  // helpers
  task automatic final_report();
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [32:0] e, input logic [32:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int w;
    if (!wr) exp_q.push_back(e);
    @(posedge sys_clk);
    apb <= '{1'b1, 1'b0, wr, a, d};
    @(posedge sys_clk);
    apb.penable <= 1'b1;
    w = 0;
    do begin
      @(posedge sys_clk);
      w++;
    end while (apb_rsp.pready !== 1'b1 && w < 50);
    if (apb_rsp.pready !== 1'b1) n_errors++;
    apb <= '0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, '0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    bus(1'b0, a, '0, e);
  endtask : rd
  task automatic send_bit(input logic b, input int len);
    @(posedge sys_clk);
    uart_txd <= b;
    uart_bit_tick <= 1'b1;
    @(posedge sys_clk);
    uart_bit_tick <= 1'b0;
    repeat (len - 2) @(posedge sys_clk);
    #1;
  endtask : send_bit
  task automatic pulse_rst(input logic main);
    @(posedge sys_clk);
    if (main) rstn <= 1'b0;
    else standby_rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    standby_rstn <= 1'b1;
    tick(2);
  endtask : pulse_rst
  task automatic busy_pulse(input logic tx, input int n);
    @(posedge sys_clk);
    if (tx) uart_tx_busy <= 1'b1;
    else uart_rx_busy <= 1'b1;
    repeat (n) @(posedge sys_clk);
    uart_tx_busy <= 1'b0;
    uart_rx_busy <= 1'b0;
  endtask : busy_pulse
  function automatic logic [32:0] pv();
    return {29'h0, tx_pins};
  endfunction : pv

  // ==========================================
  // clock, timeout, read watcher
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end
  always @(posedge sys_clk) begin
    if (apb.psel && apb.penable && !apb.pwrite && apb_rsp.pready) begin
      if (exp_q.size() == 0) chk("read queue", 33'h0, 33'h1);
      else chk("read data", exp_q.pop_front(), {apb_rsp.pslverr, apb_rsp.prdata});
    end
  end

  // ==========================================
  // scenarios
  initial begin
    int z;
    int rb;
    int hb;
    logic b;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    standby_rstn <= 1'b1;
    tick(2);
    chk("pins", 33'h5, pv());
    rd(`IRM_CTRL_OFF, 33'h0);
    rd(`IRM_MODE_OFF, 33'h0);
    rd(8'h40, {1'b1, 32'h0});
    wr(`IRM_TMO_OFF, 32'hff);
    rd(`IRM_TMO_OFF, 33'h64);
    wr(`IRM_MODE_OFF, 32'h20);
    tick(2);
    chk("pins", 33'h1, pv());
    pulse_rst(1'b1);
    chk("pins", 33'h1, pv());
    rd(`IRM_MODE_OFF, 33'h20);
    pulse_rst(1'b0);
    chk("pins", 33'h5, pv());
    wr(`IRM_GPIO_OFF, 32'h08);
    tick(2);
    chk("pins", 33'hd, pv());
    wr(`IRM_GPIO_OFF, 32'h10);
    tick(2);
    chk("pins", 33'hd, pv());
    wr(`IRM_GPIO_OFF, 32'h19);
    wr(`IRM_CTRL_OFF, 32'h40);
    tick(2);
    chk("pins", 33'h7, pv());
    wr(`IRM_GPIO_OFF, 32'h0);
    wr(`IRM_CTRL_OFF, 32'h21);
    tick(2);
    chk("pins", 33'hd, pv());
    wr(`IRM_CTRL_OFF, 32'h20);
    wr(`IRM_MODE_OFF, 32'h20);
    tick(2);
    chk("pins", 33'h1, pv());
    wr(`IRM_MODE_OFF, 32'h0);
    tick(2);
    chk("pins", 33'h5, pv());
    // frozen by clock enable: the float write must not land
    ce <= 1'b0;
    wr(`IRM_MODE_OFF, 32'h20);
    tick(2);
    chk("pins", 33'h5, pv());
    ce <= 1'b1;
    wr(`IRM_CTRL_OFF, 32'h21);
    send_bit(1'b0, 20);
    chk("pins", 33'h5, pv());
    // pulse mode: one character with random data bits
    wr(`IRM_CTRL_OFF, 32'h23);
    rb = sh_rises;
    hb = sh_high;
    z = 0;
    for (int i = 0; i < 9; i++) begin
      lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
      b = (i == 0) ? 1'b0 : lfsr[0];
      if (!b) z++;
      send_bit(b, 200);
    end
    send_bit(1'b1, 200);
    chk("pulses", 33'(z), 33'(sh_rises - rb));
    chk("pulse cycles", 33'(z * 160), 33'(sh_high - hb));
    // keyed mode: 450 cycles of zero give two carrier highs
    wr(`IRM_CTRL_OFF, 32'h27);
    rb = sh_rises;
    hb = sh_high;
    send_bit(1'b0, 450);
    send_bit(1'b1, 20);
    chk("carrier edges", 33'h2, 33'(sh_rises - rb));
    chk("carrier cycles", 33'd200, 33'(sh_high - hb));
    wr(`IRM_CTRL_OFF, 32'h33);
    rb = alt_rises;
    send_bit(1'b0, 50);
    chk("pins", 33'h7, pv());
    send_bit(1'b1, 200);
    chk("alt pulses", 33'h1, 33'(alt_rises - rb));
    // half duplex turnaround of 3 steps
    wr(`IRM_TMO_OFF, 32'h3);
    wr(`IRM_CTRL_OFF, 32'h29);
    rx_level <= 1'b0;
    busy_pulse(1'b1, 5);
    tick(20);
    chk("rx block", 33'h1, 33'(rx_block));
    chk("rxd", 33'h1, 33'(uart_rxd));
    busy_pulse(1'b1, 10);
    tick(25);
    chk("rx block", 33'h1, 33'(rx_block));
    tick(15);
    chk("rx block", 33'h0, 33'(rx_block));
    chk("rxd", 33'h0, 33'(uart_rxd));
    busy_pulse(1'b0, 10);
    tick(20);
    chk("tx hold", 33'h1, 33'(tx_hold));
    busy_pulse(1'b0, 10);
    tick(25);
    chk("tx hold", 33'h1, 33'(tx_hold));
    tick(15);
    chk("tx hold", 33'h0, 33'(tx_hold));
    wr(`IRM_TMO_OFF, 32'h0);
    busy_pulse(1'b1, 5);
    tick(3);
    chk("rx block", 33'h0, 33'(rx_block));
    tick(5);
    final_report();
  end
endmodule : tb_infrared_uart_modulator
`default_nettype wire
